/* File: verilog/dac_update_pkg.sv */
// constants, register map and carrier types for the converter update block
// assumes a 24-bit frame: device field, register address, 16-bit data
package dac_update_pkg;

  // frame layout
  localparam int FRAME_BITS  = 24;
  localparam int DATA_LSB    = 0;
  localparam int ADDR_LSB    = 16;
  localparam int DEV_LSB     = 21;

  // register offsets
  localparam logic [4:0] ADDR_DAC_INPUT      = 5'h01;
  localparam logic [4:0] ADDR_CLEAR_VALUE    = 5'h03;
  localparam logic [4:0] ADDR_GAIN_TRIM      = 5'h04;
  localparam logic [4:0] ADDR_OFFSET_TRIM    = 5'h05;
  localparam logic [4:0] ADDR_CONV_SETUP     = 5'h06;
  localparam logic [4:0] ADDR_SOFT_LOAD      = 5'h07;
  localparam logic [4:0] ADDR_KEY            = 5'h08;
  localparam logic [4:0] ADDR_GEN_SETUP_A    = 5'h09;
  localparam logic [4:0] ADDR_GEN_SETUP_B    = 5'h0A;
  localparam logic [4:0] ADDR_BUCK_SETUP_A   = 5'h0B;
  localparam logic [4:0] ADDR_BUCK_SETUP_B   = 5'h0C;
  localparam logic [4:0] ADDR_WATCHDOG_SETUP = 5'h0F;
  localparam logic [4:0] ADDR_INTEG_SETUP    = 5'h10;
  localparam logic [4:0] ADDR_MON_ADC_SETUP  = 5'h11;
  localparam logic [4:0] ADDR_ALARM_SETUP    = 5'h12;
  localparam logic [4:0] ADDR_INTEG_RESULTS  = 5'h16;

  // key codes
  localparam logic [15:0] KEY_LOCK    = 16'h4765;
  localparam logic [15:0] KEY_UNLOCK1 = 16'h896D;
  localparam logic [15:0] KEY_UNLOCK2 = 16'h57AB;
  localparam logic [15:0] KEY_RESET1  = 16'h15FA;
  localparam logic [15:0] KEY_RESET2  = 16'hAF51;

  // field positions
  localparam int SLEW_EN_BIT       = 6;   // converter_setup
  localparam int GLOBAL_LOAD_BIT   = 0;   // general_setup_b
  localparam int CAP_PROBE_BIT     = 1;   // general_setup_b
  localparam int CLEAR_ON_TRIP_BIT = 0;   // watchdog_setup
  localparam int RESET_ON_TRIP_BIT = 1;   // watchdog_setup
  localparam int LOCK_CHECK_EN_BIT = 0;   // integrity_check_setup
  localparam int DUAL_CAL_EN_BIT   = 1;
  localparam int INV_CHECK_EN_BIT  = 2;
  localparam int LATCH_WATCH_BIT   = 3;

  // reset values
  localparam logic [15:0] GAIN_RESET   = 16'hFFFF;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] INTEG_RESET  = 16'h0004;
  localparam logic [15:0] ZERO16       = 16'h0000;

  // calibration midscale and full scale
  localparam logic signed [18:0] CAL_MID = 19'sh08000;
  localparam logic signed [18:0] CAL_MAX = 19'sh0FFFF;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_UNLOCK_WAIT = 2'b01,
    KEY_RESET_WAIT = 2'b11
  } key_state_e;

  typedef struct packed {
    logic [1:0]  dev;
    logic [4:0]  addr;
    logic [15:0] data;
  } frame_s;

  // sticky flags, bit order matches the integrity_results data word
  typedef struct packed {
    logic inv_check_err;    // bit 5
    logic watchdog_fault;   // bit 4
    logic lock_check_err;   // bit 3
    logic latch_watch_err;  // bit 2
    logic dual_cal_err;     // bit 1
    logic reset_seen_flag;  // bit 0
  } diag_s;

  function automatic logic is_lockable(input logic [4:0] a);
    return (a >= ADDR_CLEAR_VALUE && a <= ADDR_CONV_SETUP) ||
           (a >= ADDR_GEN_SETUP_A && a <= ADDR_BUCK_SETUP_B) ||
           (a >= ADDR_WATCHDOG_SETUP && a <= ADDR_ALARM_SETUP);
  endfunction

endpackage

/* File: verilog/dac_update_integrity_lock.sv */
// converter output update, integrity checks, config lock and key decode
// assumes a serial host on sclk/sync_n/sdin; watchdog timing lives outside
// and reports a one-cycle timeout pulse on clk
//
// Functional notes
// - load pin low: update at frame end
// - load pin high: hold until load event
// - watchdog trip with clear bit loads clear value
// - slewing output shows instantaneous stepping value
// - watchdog fault discards input writes and loads
// - after fault, loads reapply clear until rewrite
// - global load mode ignores device address
// - inverted copy checked before strobing converter
// - dual calibration mismatch skips update, flags
// - latch readback differing from code flags error
// - locked writes ignored, fault pin, optional flag
// - lockable set 0x03-06, 0x09-0C, 0x0F-12
// - key 0x4765 locks configuration
// - unlock needs 0x896D then 0x57AB
// - no lock flag when check disabled
// - key decoder works while locked
// - software reset needs 0x15FA then 0xAF51
// - reset from pin, key pair or watchdog
// - reset flag set by resets, write-1 clears
// - code = D*(gain+1)/65536 + offset - 32768
// - write-1 re-evaluates sticky flags
`timescale 1ns/1ps

module dac_update_integrity_lock
  import dac_update_pkg::*;
#(
  parameter int          SLEW_DIV  = 16,
  parameter logic [15:0] SLEW_STEP = 16'h0010
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // serial link
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        sdin,
  // pins
  input  wire logic        load_strobe_n,
  input  wire logic [1:0]  dev_addr_pins,
  output logic             fault_n,
  // converter side
  input  wire logic        watchdog_timeout,
  input  wire logic [15:0] latch_readback,
  output logic [15:0]      dac_code,
  output logic [15:0]      dac_code_inv,
  output logic             slew_busy,
  // status and key actions
  output diag_s            diag_flags,
  output logic             config_locked,
  output logic             key_pulse,
  output logic [15:0]      key_code,
  output logic             soft_reset_pulse
);

  // link domain: shift register, bit count and captured frame
  logic [FRAME_BITS-1:0] shift_reg;
  logic [4:0]            bit_cnt_reg;
  frame_s                frame_hold_reg;
  logic                  frame_tgl_reg;

  // the frame select resets the counter so a stopped sclk leaves no residue
  always_ff @(posedge sclk or posedge sync_n or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (sync_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (bit_cnt_reg != 5'(FRAME_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (!sync_n) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], sdin};
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_hold_reg <= '0;
      frame_tgl_reg  <= 1'b0;
    end else if (!sync_n && bit_cnt_reg == 5'(FRAME_BITS - 1)) begin
      frame_hold_reg <= frame_s'({shift_reg[$bits(frame_s)-2:0], sdin});
      frame_tgl_reg  <= ~frame_tgl_reg;
    end
  end

  // crossings into clk: toggle, frame select, load pin, straps, readback
  logic [2:0]  tgl_sync_reg;
  logic [2:0]  sel_sync_reg;
  logic [2:0]  ld_sync_reg;
  logic [1:0]  dev_s1_reg;
  logic [1:0]  dev_s2_reg;
  logic [15:0] rb_s1_reg;
  logic [15:0] rb_s2_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_reg <= 3'h0;
      sel_sync_reg <= 3'h7;
      ld_sync_reg  <= 3'h7;
      dev_s1_reg   <= 2'h0;
      dev_s2_reg   <= 2'h0;
      rb_s1_reg    <= ZERO16;
      rb_s2_reg    <= ZERO16;
    end else if (clk_en) begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], frame_tgl_reg};
      sel_sync_reg <= {sel_sync_reg[1:0], sync_n};
      ld_sync_reg  <= {ld_sync_reg[1:0], load_strobe_n};
      dev_s1_reg   <= dev_addr_pins;
      dev_s2_reg   <= dev_s1_reg;
      rb_s1_reg    <= latch_readback;
      rb_s2_reg    <= rb_s1_reg;
    end
  end

  logic   frame_new;
  logic   sel_rise;
  logic   ld_fall;
  logic   ld_low;
  frame_s frm;

  // the hold register is stable once its toggle has crossed
  assign frame_new = clk_en && (tgl_sync_reg[2] != tgl_sync_reg[1]);
  assign sel_rise  = clk_en && sel_sync_reg[1] && !sel_sync_reg[2];
  assign ld_fall   = clk_en && !ld_sync_reg[1] && ld_sync_reg[2];
  assign ld_low    = !ld_sync_reg[1];
  assign frm       = frame_hold_reg;

  // configuration registers
  logic [15:0] clear_value_reg;
  logic [15:0] gain_trim_reg;
  logic [15:0] offset_trim_reg;
  logic [15:0] converter_setup_reg;
  logic [15:0] general_setup_a_reg;
  logic [15:0] general_setup_b_reg;
  logic [15:0] buck_setup_a_reg;
  logic [15:0] buck_setup_b_reg;
  logic [15:0] watchdog_setup_reg;
  logic [15:0] integrity_check_setup_reg;
  logic [15:0] monitor_adc_setup_reg;
  logic [15:0] alarm_pin_setup_reg;
  logic        locked_reg;
  key_state_e  key_state_reg;
  diag_s       diag_reg;

  logic wr_cfg;
  logic wr_locked;
  logic wr_key;
  logic sw_reset;
  logic wd_reset;
  logic sync_clear;

  assign wr_key    = frame_new && frm.addr == ADDR_KEY;
  assign wr_cfg    = frame_new && is_lockable(frm.addr) && !locked_reg;
  // key register sits outside the lockable set
  assign wr_locked = frame_new && is_lockable(frm.addr) && locked_reg;
  assign sw_reset  = wr_key && key_state_reg == KEY_RESET_WAIT &&
                     frm.data == KEY_RESET2;
  assign wd_reset  = watchdog_timeout && clk_en &&
                     watchdog_setup_reg[RESET_ON_TRIP_BIT];
  assign sync_clear = sw_reset || wd_reset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_value_reg           <= ZERO16;
      gain_trim_reg             <= GAIN_RESET;
      offset_trim_reg           <= OFFSET_RESET;
      converter_setup_reg       <= ZERO16;
      general_setup_a_reg       <= ZERO16;
      general_setup_b_reg       <= ZERO16;
      buck_setup_a_reg          <= ZERO16;
      buck_setup_b_reg          <= ZERO16;
      watchdog_setup_reg        <= ZERO16;
      integrity_check_setup_reg <= INTEG_RESET;
      monitor_adc_setup_reg     <= ZERO16;
      alarm_pin_setup_reg       <= ZERO16;
    end else if (sync_clear) begin
      clear_value_reg           <= ZERO16;
      gain_trim_reg             <= GAIN_RESET;
      offset_trim_reg           <= OFFSET_RESET;
      converter_setup_reg       <= ZERO16;
      general_setup_a_reg       <= ZERO16;
      general_setup_b_reg       <= ZERO16;
      buck_setup_a_reg          <= ZERO16;
      buck_setup_b_reg          <= ZERO16;
      watchdog_setup_reg        <= ZERO16;
      integrity_check_setup_reg <= INTEG_RESET;
      monitor_adc_setup_reg     <= ZERO16;
      alarm_pin_setup_reg       <= ZERO16;
    end else if (wr_cfg) begin
      case (frm.addr)
        ADDR_CLEAR_VALUE:    clear_value_reg           <= frm.data;
        ADDR_GAIN_TRIM:      gain_trim_reg             <= frm.data;
        ADDR_OFFSET_TRIM:    offset_trim_reg           <= frm.data;
        ADDR_CONV_SETUP:     converter_setup_reg       <= frm.data;
        ADDR_GEN_SETUP_A:    general_setup_a_reg       <= frm.data;
        ADDR_GEN_SETUP_B:    general_setup_b_reg       <= frm.data;
        ADDR_BUCK_SETUP_A:   buck_setup_a_reg          <= frm.data;
        ADDR_BUCK_SETUP_B:   buck_setup_b_reg          <= frm.data;
        ADDR_WATCHDOG_SETUP: watchdog_setup_reg        <= frm.data;
        ADDR_INTEG_SETUP:    integrity_check_setup_reg <= frm.data;
        ADDR_MON_ADC_SETUP:  monitor_adc_setup_reg     <= frm.data;
        ADDR_ALARM_SETUP:    alarm_pin_setup_reg       <= frm.data;
        default:             clear_value_reg           <= clear_value_reg;
      endcase
    end
  end

  // key decoder; every key write either completes a pair or starts over
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_state_reg <= KEY_IDLE;
      locked_reg    <= 1'b0;
    end else if (sync_clear) begin
      key_state_reg <= KEY_IDLE;
      locked_reg    <= 1'b0;
    end else if (wr_key) begin
      case (key_state_reg)
        KEY_UNLOCK_WAIT: begin
          if (frm.data == KEY_UNLOCK2) begin
            locked_reg <= 1'b0;
          end
          key_state_reg <= KEY_IDLE;
        end
        KEY_RESET_WAIT: begin
          key_state_reg <= KEY_IDLE;
        end
        default: begin
          if (frm.data == KEY_LOCK) begin
            locked_reg <= 1'b1;
          end
          if (frm.data == KEY_UNLOCK1) begin
            key_state_reg <= KEY_UNLOCK_WAIT;
          end else if (frm.data == KEY_RESET1) begin
            key_state_reg <= KEY_RESET_WAIT;
          end else begin
            key_state_reg <= KEY_IDLE;
          end
        end
      endcase
    end
  end

  // other key codes go out for the refresh, conversion, kick and crc units
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_pulse        <= 1'b0;
      key_code         <= ZERO16;
      soft_reset_pulse <= 1'b0;
    end else if (clk_en) begin
      key_pulse        <= wr_key;
      soft_reset_pulse <= sync_clear;
      if (wr_key) begin
        key_code <= frm.data;
      end
    end
  end

  // calibration, computed twice so a transient upset shows as a mismatch
  function automatic logic [15:0] calibrate(input logic [15:0] d,
                                            input logic [15:0] m,
                                            input logic [15:0] c);
    logic [32:0]       prod;
    logic signed [18:0] sum;
    prod = {17'h00000, d} * {17'h00000, m} + {17'h00000, d};
    sum  = $signed({2'b00, prod[32:16]}) + $signed({3'b000, c}) - CAL_MID;
    if (sum < 0) begin
      return ZERO16;
    end else if (sum > CAL_MAX) begin
      return 16'hFFFF;
    end
    return sum[15:0];
  endfunction

  logic [15:0] cal_a;
  logic [15:0] cal_b;
  logic        watchdog_fault;
  logic        input_wr;
  logic        cal_mismatch;

  assign cal_a = calibrate(frm.data, gain_trim_reg, offset_trim_reg);
  assign cal_b = calibrate(frm.data, gain_trim_reg, offset_trim_reg);
  assign watchdog_fault = diag_reg.watchdog_fault;
  assign input_wr = frame_new && frm.addr == ADDR_DAC_INPUT &&
                    !watchdog_fault;
  assign cal_mismatch = integrity_check_setup_reg[DUAL_CAL_EN_BIT] &&
                        cal_a != cal_b;

  // target code with its inverted copy
  logic [15:0] target_reg;
  logic [15:0] target_inv_reg;
  logic        pending_reg;
  logic        clear_hold_reg;
  logic        arm_frame_end_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_reg     <= ZERO16;
      target_inv_reg <= ~ZERO16;
    end else if (input_wr && !cal_mismatch) begin
      target_reg     <= cal_a;
      target_inv_reg <= ~cal_b;
    end
  end

  logic soft_load;
  logic load_evt;
  logic inv_bad;
  logic do_load;
  logic wd_clear;

  assign soft_load = frame_new && frm.addr == ADDR_SOFT_LOAD &&
                     (general_setup_b_reg[GLOBAL_LOAD_BIT] ||
                      frm.dev == dev_s2_reg);
  // frame end with pin low, pin pulse, or soft command
  assign load_evt = !watchdog_fault &&
                    ((sel_rise && arm_frame_end_reg && ld_low) ||
                     (ld_fall && pending_reg) || soft_load);
  assign inv_bad  = integrity_check_setup_reg[INV_CHECK_EN_BIT] &&
                    target_reg != ~target_inv_reg;
  assign do_load  = load_evt && (clear_hold_reg || !inv_bad);
  assign wd_clear = watchdog_timeout && clk_en &&
                    watchdog_setup_reg[CLEAR_ON_TRIP_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg       <= 1'b0;
      arm_frame_end_reg <= 1'b0;
      clear_hold_reg    <= 1'b0;
    end else if (clk_en) begin
      if (input_wr && !cal_mismatch) begin
        pending_reg       <= 1'b1;
        arm_frame_end_reg <= 1'b1;
      end else begin
        if (sel_rise) begin
          arm_frame_end_reg <= 1'b0;
        end
        if (do_load) begin
          pending_reg <= 1'b0;
        end
      end
      if (wd_clear) begin
        clear_hold_reg <= 1'b1;
      end else if (input_wr && !cal_mismatch) begin
        clear_hold_reg <= 1'b0;
      end
    end
  end

  // output code, stepped toward the goal when slewing
  logic [15:0] goal_reg;
  logic [15:0] out_reg;
  logic [$clog2(SLEW_DIV+1)-1:0] slew_cnt_reg;
  logic        slew_en;
  logic        slew_tick;

  assign slew_en   = converter_setup_reg[SLEW_EN_BIT];
  assign slew_tick = slew_cnt_reg == '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slew_cnt_reg <= '0;
    end else if (clk_en) begin
      if (slew_tick) begin
        slew_cnt_reg <= ($clog2(SLEW_DIV+1))'(SLEW_DIV - 1);
      end else begin
        slew_cnt_reg <= slew_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      goal_reg <= ZERO16;
      out_reg  <= ZERO16;
    end else if (clk_en) begin
      if (wd_clear) begin
        goal_reg <= clear_value_reg;
        out_reg  <= clear_value_reg;
      end else if (do_load) begin
        goal_reg <= clear_hold_reg ? clear_value_reg : target_reg;
        if (!slew_en) begin
          out_reg <= clear_hold_reg ? clear_value_reg : target_reg;
        end
      end else if (!slew_en) begin
        out_reg <= goal_reg;
      end else if (slew_tick && out_reg != goal_reg) begin
        if (goal_reg > out_reg) begin
          out_reg <= (goal_reg - out_reg > SLEW_STEP) ?
                     out_reg + SLEW_STEP : goal_reg;
        end else begin
          out_reg <= (out_reg - goal_reg > SLEW_STEP) ?
                     out_reg - SLEW_STEP : goal_reg;
        end
      end
    end
  end

  // readback trails the code by the two synchroniser stages; a direct
  // compare would flag every legitimate code step, so delay the code alike
  logic [15:0] code_d1_reg;
  logic [15:0] code_d2_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_d1_reg <= ZERO16;
      code_d2_reg <= ZERO16;
    end else if (clk_en) begin
      code_d1_reg <= out_reg;
      code_d2_reg <= code_d1_reg;
    end
  end

  // sticky flags: set beats clear, write-1 takes the live condition
  diag_s flag_set;
  diag_s flag_live;
  diag_s flag_w1;
  logic  latch_diff;
  logic  lock_hit_reg;

  assign latch_diff = integrity_check_setup_reg[LATCH_WATCH_BIT] &&
                      rb_s2_reg != code_d2_reg;
  assign flag_w1 = (frame_new && frm.addr == ADDR_INTEG_RESULTS) ?
                   diag_s'(frm.data[$bits(diag_s)-1:0]) : diag_s'('0);

  always_comb begin
    flag_set = '0;
    flag_set.reset_seen_flag = sync_clear;
    flag_set.dual_cal_err    = input_wr && cal_mismatch;
    flag_set.latch_watch_err = clk_en && latch_diff;
    flag_set.lock_check_err  = wr_locked &&
      integrity_check_setup_reg[LOCK_CHECK_EN_BIT];
    flag_set.watchdog_fault  = watchdog_timeout && clk_en;
    flag_set.inv_check_err   = load_evt && !clear_hold_reg && inv_bad;
    flag_live = '0;
    flag_live.latch_watch_err = latch_diff;
    flag_live.inv_check_err   = inv_bad;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_reg <= diag_s'(1);
    end else if (clk_en) begin
      diag_reg <= flag_set | (diag_reg & ~flag_w1) |
                  (flag_w1 & flag_live);
    end
  end

  // a locked write pulls the alarm until the results are next written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_hit_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_locked) begin
        lock_hit_reg <= 1'b1;
      end else if (frame_new && frm.addr == ADDR_INTEG_RESULTS) begin
        lock_hit_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_n <= 1'b1;
    end else if (clk_en) begin
      fault_n <= !(lock_hit_reg || wr_locked ||
                   (|(diag_reg & ~diag_s'(1))));
    end
  end

  assign dac_code      = out_reg;
  assign dac_code_inv  = ~out_reg;
  assign slew_busy     = out_reg != goal_reg;
  assign diag_flags    = diag_reg;
  assign config_locked = locked_reg;

endmodule

/* File: tb/dac_update_integrity_lock_checker.sv */
// port assertions for the converter update block
// assumes one clk domain on the checked outputs; bound to every instance
`timescale 1ns/1ps

module dac_update_integrity_lock_checker
  import dac_update_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // observed ports
  input wire logic        watchdog_timeout,
  input wire logic        fault_n,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] dac_code_inv,
  input wire logic        slew_busy,
  input wire diag_s       diag_flags,
  input wire logic        config_locked,
  input wire logic        key_pulse,
  input wire logic [15:0] key_code,
  input wire logic        soft_reset_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_inv;
    dac_code_inv == ~dac_code;
  endproperty
  a_inv: assert property (p_inv) else $error("inverse copy differs");
  property p_trip;
    watchdog_timeout && clk_en |=> diag_flags.watchdog_fault;
  endproperty
  a_trip: assert property (p_trip) else $error("no fault on trip");
  // slewing may still run out after a trip, so only settled output is held
  property p_hold;
    diag_flags.watchdog_fault && $past(diag_flags.watchdog_fault) &&
      !slew_busy |-> $stable(dac_code);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved in fault");
  property p_lock_pin;
    $rose(diag_flags.lock_check_err) |-> ##[0:1] !fault_n;
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("pin idle");
  property p_locks;
    key_pulse && key_code == KEY_LOCK |-> ##[0:1] config_locked;
  endproperty
  a_locks: assert property (p_locks) else $error("lock key ignored");
  property p_unlock;
    $fell(config_locked) |->
      (##[0:1] key_code == KEY_UNLOCK2) or (##[0:1] soft_reset_pulse);
  endproperty
  a_unlock: assert property (p_unlock) else $error("bad unlock");
  property p_soft;
    soft_reset_pulse |-> diag_flags.reset_seen_flag && !config_locked;
  endproperty
  a_soft: assert property (p_soft) else $error("reset effects");
  property p_key_pulse;
    key_pulse |=> !key_pulse;
  endproperty
  a_key_pulse: assert property (p_key_pulse) else $error("long key");
endmodule

bind dac_update_integrity_lock dac_update_integrity_lock_checker u_chk (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .watchdog_timeout(watchdog_timeout), .fault_n(fault_n),
  .dac_code(dac_code), .dac_code_inv(dac_code_inv), .slew_busy(slew_busy),
  .diag_flags(diag_flags), .config_locked(config_locked),
  .key_pulse(key_pulse), .key_code(key_code),
  .soft_reset_pulse(soft_reset_pulse)
);

/* File: tb/spi_host_model.sv */
// serial host driving 24-bit frames, msb first, sclk idle low
// assumes the device samples sdin on the rising sclk edge
`timescale 1ns/1ps

module spi_host_model
  import dac_update_pkg::*;
(
  // link pins
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdin = 1'b0;
  end

  task automatic send(input frame_s f);
    logic [23:0] w;
    w = {1'b0, f};
    #3.3 sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = w[i];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    // released line shows the inverse so a stale bit is never trusted
    sdin = ~w[0];
    #7.5 sync_n = 1'b1;
    #90;
  endtask
endmodule

/* File: tb/dac_update_integrity_lock_bench.sv */
// self-checking bench for the converter update block
// assumes the host model owns the link and this bench the pins
`timescale 1ns/1ps

module dac_update_integrity_lock_bench;
  import dac_update_pkg::*;
  logic        clk, rst_n, ld_n, wd_trip, latch_flip, ce;
  logic        sclk, sync_n, sdin, fault_n, slew_busy, config_locked;
  logic [15:0] dac_code;
  diag_s       diag_flags;
  int          err_count, total_checks;

  spi_host_model host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  dac_update_integrity_lock #(.SLEW_DIV(2)) dut (
    .clk(clk), .rst_n(rst_n), .clk_en(ce), .sclk(sclk), .sync_n(sync_n),
    .sdin(sdin), .load_strobe_n(ld_n), .dev_addr_pins(2'b01),
    .fault_n(fault_n), .watchdog_timeout(wd_trip),
    .latch_readback(dac_code ^ {16{latch_flip}}), .dac_code(dac_code),
    .dac_code_inv(), .slew_busy(slew_busy), .diag_flags(diag_flags),
    .config_locked(config_locked), .key_pulse(), .key_code(),
    .soft_reset_pulse());

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [15:0] st();
    return {fault_n, config_locked, slew_busy, 7'h00, diag_flags};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d,
                    input logic [1:0] dv = 2'b01);
    host.send('{dv, a, d});
  endtask
  task automatic pin(input logic v);
    @(negedge clk);
    ld_n = v;
    ticks(4);
  endtask
  // one-cycle watchdog pulse; e low freezes the block for that cycle
  task automatic trip(input logic e);
    @(negedge clk);
    ce = e;
    wd_trip = 1'b1;
    @(negedge clk);
    wd_trip = 1'b0;
    ce = 1'b1;
    ticks(2);
  endtask

  task automatic t_load();
    check(st(), 16'h8001);
    wr(ADDR_GAIN_TRIM, 16'h7FFF);
    wr(ADDR_OFFSET_TRIM, 16'h8010);
    wr(ADDR_DAC_INPUT, 16'h4000);
    check(dac_code, 16'h2010);
    pin(1'b1);
    wr(ADDR_DAC_INPUT, 16'h1000);
    check(dac_code, 16'h2010);
    pin(1'b0);
    pin(1'b1);
    check(dac_code, 16'h0810);
    wr(ADDR_DAC_INPUT, 16'h2000);
    wr(ADDR_SOFT_LOAD, 16'h0000, 2'b10);
    check(dac_code, 16'h0810);
    wr(ADDR_SOFT_LOAD, 16'h0000);
    check(dac_code, 16'h1010);
    wr(ADDR_GEN_SETUP_B, 16'h0001); // probe bit left clear
    wr(ADDR_DAC_INPUT, 16'h3000);
    wr(ADDR_SOFT_LOAD, 16'h0000, 2'b10);
    check(dac_code, 16'h1810);
  endtask

  task automatic t_lock();
    wr(ADDR_CLEAR_VALUE, 16'h0ABC);
    wr(ADDR_KEY, KEY_LOCK);
    check(st(), 16'hC001);
    wr(ADDR_CLEAR_VALUE, 16'h1234);
    check(st(), 16'h4001);
    wr(ADDR_INTEG_RESULTS, 16'h0008);
    wr(ADDR_KEY, KEY_UNLOCK1);
    wr(ADDR_KEY, KEY_RESET1);
    wr(ADDR_KEY, KEY_UNLOCK2);
    check(st(), 16'hC001);
    wr(ADDR_KEY, KEY_UNLOCK1);
    wr(ADDR_KEY, KEY_UNLOCK2);
    check(st(), 16'h8001);
    wr(ADDR_INTEG_SETUP, 16'h0005);
    wr(ADDR_KEY, KEY_LOCK);
    wr(ADDR_ALARM_SETUP, 16'h0000);
    check(st(), 16'h4009);
    wr(ADDR_INTEG_RESULTS, 16'h0008);
    wr(ADDR_KEY, KEY_UNLOCK1);
    wr(ADDR_KEY, KEY_UNLOCK2);
    check(st(), 16'h8001);
  endtask

  task automatic t_latch();
    wr(ADDR_INTEG_SETUP, 16'h000C);
    @(negedge clk);
    latch_flip = 1'b1;
    ticks(6);
    check(st(), 16'h0005);
    @(negedge clk);
    latch_flip = 1'b0;
    wr(ADDR_INTEG_SETUP, 16'h0004);
    wr(ADDR_INTEG_RESULTS, 16'h0004);
    check(st(), 16'h8001);
  endtask

  task automatic t_watchdog();
    wr(ADDR_WATCHDOG_SETUP, 16'h0001);
    trip(1'b1);
    check(dac_code, 16'h0ABC);
    check(st(), 16'h0011);
    wr(ADDR_DAC_INPUT, 16'h0000);
    wr(ADDR_SOFT_LOAD, 16'h0000);
    check(dac_code, 16'h0ABC);
    wr(ADDR_INTEG_RESULTS, 16'h0010);
    wr(ADDR_SOFT_LOAD, 16'h0000);
    check(dac_code, 16'h0ABC);
    wr(ADDR_DAC_INPUT, 16'h2000);
    wr(ADDR_SOFT_LOAD, 16'h0000);
    check(dac_code, 16'h1010);
  endtask

  task automatic t_soft_slew();
    wr(ADDR_INTEG_RESULTS, 16'h0001);
    check(st(), 16'h8000);
    wr(ADDR_KEY, KEY_LOCK);
    wr(ADDR_KEY, KEY_RESET1);
    wr(ADDR_KEY, KEY_RESET2);
    check(st(), 16'h8001);
    wr(ADDR_CONV_SETUP, 16'h0040);
    wr(ADDR_DAC_INPUT, 16'h2000);
    wr(ADDR_SOFT_LOAD, 16'h0000);
    check(st(), 16'hA001);
    for (int i = 0; i < 2000 && slew_busy !== 1'b0; i++)
      @(negedge clk);
    check(dac_code, 16'h2000);
  endtask

  // watchdog set to reset: a frozen cycle ignores the trip, a live one acts
  task automatic t_wd_reset();
    wr(ADDR_INTEG_RESULTS, 16'h0001);
    wr(ADDR_WATCHDOG_SETUP, 16'h0002);
    trip(1'b0);
    check(st(), 16'h8000);
    trip(1'b1);
    check(st(), 16'h0011);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    ld_n = 1'b0;
    ce = 1'b1;
    wd_trip = 1'b0;
    latch_flip = 1'b0;
    err_count = 0;
    total_checks = 0;
    ticks(4);
    rst_n = 1'b1;
    ticks(2);
    t_load();
    t_lock();
    t_latch();
    t_watchdog();
    t_soft_slew();
    t_wd_reset();
    end_of_test();
  end

  // the whole run needs about 25 us; this cuts a hang short
  initial begin
    #200us;
    err_count++;
    end_of_test();
  end
endmodule
